// [logic/aps_point_parser.sv]
// How it works
// - 'W' then format letter selects point decoding
// - one second without characters ends download
// - hex point: one to four digits, zero-extended
// - hex letters accepted in either case
// - any non-hex character separates hex points
// - hex digits arrive most significant nibble first
// - low-byte bit 3 drives sync during point
// - binary point: high byte then low byte
// - binary data follows format letter immediately
// - points are sixteen-bit two's complement
// - only upper twelve bits reach the DAC
// - store holds up to 32768 points
// - serial framing: start, eight data, stop, no parity
module aps_point_parser #(
    parameter int unsigned IDLE_CYCLES = aps_pkg::IDLE_CYCLES  // idle cycles that end a download
) (
    input wire logic mclk_i,              // system clock, 100 MHz
    input wire logic rst_b_i,             // synchronous reset, active low
    input wire logic rxd_i,               // serial line from the host
    input wire logic [19:0] baud_div_i,   // clock cycles per bit
    input wire logic sample_tick_i,       // one-cycle pulse per output sample
    output logic [11:0] dac_o,            // two's complement DAC sample
    output logic sync_o,                  // sync marker of the playing point
    output logic playing_o,               // stored waveform is playing
    output logic loading_o,               // a download is in progress
    output logic [15:0] wave_len_o        // points in the stored waveform
);
    typedef struct packed {
        aps_pkg::aps_pstate_t ps;
        logic [15:0] acc;
        logic [2:0] ndig;
        logic [7:0] hi;
        logic [15:0] cnt;
        logic [15:0] len;
        logic [26:0] idle;
        logic play;
        logic [14:0] rd_addr;
        logic [11:0] dac;
        logic sync;
    } aps_parse_t;

    // timeout fires on the last count, so the quiet gap is exactly IDLE_CYCLES clocks
    localparam logic [26:0] IDLE_LAST = 27'(IDLE_CYCLES - 1);

    aps_parse_t cur_ff;
    aps_parse_t nxt_cur;
    logic [7:0] rx_byte;
    logic rx_vld;
    // each entry holds the twelve DAC bits above the marker bit
    logic [aps_pkg::ENTRY_W-1:0] store_mem [aps_pkg::STORE_DEPTH];
    logic [aps_pkg::ENTRY_W-1:0] rd_q_ff;
    logic wr_en;
    logic [14:0] wr_addr;
    logic [aps_pkg::ENTRY_W-1:0] wr_data;
    logic commit;
    logic [15:0] commit_pt;
    logic dl_done;
    logic [4:0] nib;
    logic [7:0] fmt_ch;

    // returns {valid, nibble}; letters folded to upper case first
    function automatic logic [4:0] hex_nib(input logic [7:0] c);
        logic [7:0] u;
        u = c & aps_pkg::CH_CASE_MASK;
        if (c >= aps_pkg::CH_0 && c <= aps_pkg::CH_9) begin
            hex_nib = {1'b1, c[3:0]};
        end else if (u >= aps_pkg::CH_A && u <= aps_pkg::CH_F) begin
            hex_nib = {1'b1, 4'(u - aps_pkg::CH_A) + aps_pkg::NIB_A};
        end else begin
            hex_nib = 5'h00;
        end
    endfunction : hex_nib

    aps_uart_rx aps_uart_rx_inst (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .rxd_i(rxd_i),
        .baud_div_i(baud_div_i),
        .byte_o(rx_byte),
        .byte_vld_o(rx_vld)
    );

    always_comb begin
        nxt_cur = cur_ff;
        commit = 1'b0;
        commit_pt = 16'h0000;
        dl_done = 1'b0;
        wr_en = 1'b0;
        wr_addr = cur_ff.cnt[14:0];
        wr_data = '0;
        nib = hex_nib(rx_byte);
        fmt_ch = rx_byte & aps_pkg::CH_CASE_MASK;
        if (cur_ff.ps != aps_pkg::PS_HEADER) begin
            nxt_cur.idle = cur_ff.idle + 27'h1;
        end
        if (rx_vld) begin
            nxt_cur.idle = 27'h0;
            case (cur_ff.ps)
                aps_pkg::PS_HEADER: begin
                    if (rx_byte == aps_pkg::CH_INTRO) begin
                        nxt_cur.ps = aps_pkg::PS_FORMAT;
                    end
                end
                aps_pkg::PS_FORMAT: begin
                    // a valid format letter stops playback and restarts the store
                    nxt_cur.play = 1'b0;
                    nxt_cur.cnt = 16'h0000;
                    nxt_cur.acc = 16'h0000;
                    nxt_cur.ndig = 3'h0;
                    nxt_cur.rd_addr = 15'h0000;
                    case (fmt_ch)
                        aps_pkg::CH_HEX: nxt_cur.ps = aps_pkg::PS_HEX;
                        aps_pkg::CH_BIN: nxt_cur.ps = aps_pkg::PS_BIN_HI;
                        aps_pkg::CH_FLOAT: nxt_cur.ps = aps_pkg::PS_OTHER;
                        aps_pkg::CH_INT: nxt_cur.ps = aps_pkg::PS_OTHER;
                        default: begin
                            nxt_cur.ps = aps_pkg::PS_HEADER;
                            nxt_cur.play = cur_ff.play;
                            nxt_cur.cnt = cur_ff.cnt;
                        end
                    endcase
                end
                aps_pkg::PS_HEX: begin
                    if (nib[4]) begin
                        // a fifth digit is ignored; fewer leave upper bits zero
                        if (cur_ff.ndig < aps_pkg::HEX_DIGITS_MAX) begin
                            nxt_cur.acc = {cur_ff.acc[11:0], nib[3:0]};
                            nxt_cur.ndig = cur_ff.ndig + 3'h1;
                        end
                    end else begin
                        if (cur_ff.ndig != 3'h0) begin
                            commit = 1'b1;
                            commit_pt = cur_ff.acc;
                        end
                        nxt_cur.acc = 16'h0000;
                        nxt_cur.ndig = 3'h0;
                    end
                end
                aps_pkg::PS_BIN_HI: begin
                    // no whitespace skipping: every byte after the letter is data
                    nxt_cur.hi = rx_byte;
                    nxt_cur.ps = aps_pkg::PS_BIN_LO;
                end
                aps_pkg::PS_BIN_LO: begin
                    commit = 1'b1;
                    commit_pt = {cur_ff.hi, rx_byte};
                    nxt_cur.ps = aps_pkg::PS_BIN_HI;
                end
                aps_pkg::PS_OTHER: begin
                    // float and integer text is swallowed until the timeout
                    nxt_cur.ps = aps_pkg::PS_OTHER;
                end
                default: begin
                    nxt_cur.ps = aps_pkg::PS_HEADER;
                end
            endcase
        end else if (cur_ff.ps != aps_pkg::PS_HEADER && cur_ff.idle == IDLE_LAST) begin
            // a hex point still open at the timeout is kept
            if (cur_ff.ps == aps_pkg::PS_HEX && cur_ff.ndig != 3'h0) begin
                commit = 1'b1;
                commit_pt = cur_ff.acc;
            end
            dl_done = cur_ff.ps != aps_pkg::PS_FORMAT;
            nxt_cur.ps = aps_pkg::PS_HEADER;
            nxt_cur.idle = 27'h0;
        end
        // once full, points are dropped and the count stays at the store size
        if (commit && cur_ff.cnt != aps_pkg::STORE_FULL) begin
            wr_en = 1'b1;
            // sample keeps bits 15..4, marker is bit 3
            wr_data = {commit_pt[15:aps_pkg::DAC_LSB], commit_pt[aps_pkg::SYNC_BIT]};
            nxt_cur.cnt = cur_ff.cnt + 16'h1;
        end
        // length and playback change on the same edge at which loading falls
        if (dl_done) begin
            nxt_cur.len = nxt_cur.cnt;
            nxt_cur.play = nxt_cur.cnt != 16'h0000;
            nxt_cur.rd_addr = 15'h0000;
        end
        // read data trails rd_addr by one cycle, so ticks must be two or more apart
        if (cur_ff.play && sample_tick_i) begin
            nxt_cur.dac = rd_q_ff[aps_pkg::ENTRY_W-1:1];
            nxt_cur.sync = rd_q_ff[0];
            if (cur_ff.rd_addr == 15'(cur_ff.len - 16'h1)) begin
                nxt_cur.rd_addr = 15'h0000;
            end else begin
                nxt_cur.rd_addr = cur_ff.rd_addr + 15'h1;
            end
        end else if (!cur_ff.play) begin
            nxt_cur.dac = 12'h000;
            nxt_cur.sync = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // sample store: one write port from the parser, one read port for playback
    always_ff @(posedge mclk_i) begin
        if (wr_en) begin
            store_mem[wr_addr] <= wr_data;
        end
        rd_q_ff <= store_mem[cur_ff.rd_addr];
    end

    assign dac_o = cur_ff.dac;
    assign sync_o = cur_ff.sync;
    assign playing_o = cur_ff.play;
    assign loading_o = cur_ff.ps != aps_pkg::PS_HEADER;
    assign wave_len_o = cur_ff.len;
endmodule : aps_point_parser

// [pkg/aps_pkg.sv]
package aps_pkg;
    // clock and timing
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned IDLE_TIME_S = 1;
    localparam int unsigned IDLE_CYCLES = IDLE_TIME_S * CLK_FREQ_HZ;
    localparam int unsigned IDLE_CNT_W = 27;
    // serial link
    localparam int unsigned BAUD_MIN_BPS = 300;
    localparam int unsigned BAUD_MAX_BPS = 115200;
    localparam int unsigned BAUD_DIV_W = 20;
    localparam logic [19:0] BAUD_DIV_MIN = 20'(CLK_FREQ_HZ / BAUD_MAX_BPS);
    localparam logic [19:0] BAUD_DIV_MAX = 20'(CLK_FREQ_HZ / BAUD_MIN_BPS);
    localparam logic [2:0] DATA_BITS_LAST = 3'h7;
    // sample store
    localparam int unsigned STORE_DEPTH = 32768;
    localparam int unsigned ADDR_W = 15;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned POINT_W = 16;
    localparam int unsigned DAC_W = 12;
    localparam int unsigned ENTRY_W = 13;
    localparam int unsigned DAC_LSB = 4;
    localparam int unsigned SYNC_BIT = 3;
    localparam logic [15:0] STORE_FULL = 16'h8000;
    localparam logic [2:0] HEX_DIGITS_MAX = 3'h4;
    // characters
    localparam logic [7:0] CH_INTRO = 8'h57;
    localparam logic [7:0] CH_FLOAT = 8'h46;
    localparam logic [7:0] CH_INT = 8'h49;
    localparam logic [7:0] CH_HEX = 8'h48;
    localparam logic [7:0] CH_BIN = 8'h42;
    localparam logic [7:0] CH_CASE_MASK = 8'hdf;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [3:0] NIB_A = 4'ha;

    typedef enum logic [2:0] {
        PS_HEADER = 3'b000,
        PS_FORMAT = 3'b001,
        PS_HEX = 3'b010,
        PS_BIN_HI = 3'b011,
        PS_BIN_LO = 3'b100,
        PS_OTHER = 3'b101
    } aps_pstate_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } aps_rxstate_t;
endpackage : aps_pkg

// [logic/aps_uart_rx.sv]
module aps_uart_rx (
    input wire logic mclk_i,              // system clock
    input wire logic rst_b_i,             // synchronous reset, active low
    input wire logic rxd_i,               // serial line from the host
    input wire logic [19:0] baud_div_i,   // clock cycles per bit
    output logic [7:0] byte_o,            // last received byte
    output logic byte_vld_o               // one-cycle pulse per good byte
);
    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        aps_pkg::aps_rxstate_t st;
        logic [19:0] cnt;
        logic [2:0] bitn;
        logic [7:0] shreg;
        logic [7:0] data;
        logic vld;
    } aps_rx_t;

    // the line idles high, so the synchroniser resets high: no false start after reset
    localparam aps_rx_t RX_RST = aps_rx_t'({2'b11, 42'h000});

    aps_rx_t cur_ff;
    aps_rx_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rx_s1 = rxd_i;
        nxt_cur.rx_s2 = cur_ff.rx_s1;
        nxt_cur.vld = 1'b0;
        case (cur_ff.st)
            aps_pkg::RX_IDLE: begin
                if (!cur_ff.rx_s2) begin
                    nxt_cur.st = aps_pkg::RX_START;
                    nxt_cur.cnt = {1'b0, baud_div_i[19:1]};
                end
            end
            aps_pkg::RX_START: begin
                // start bit checked again at mid-bit to reject glitches
                if (cur_ff.cnt == 20'h0) begin
                    if (!cur_ff.rx_s2) begin
                        nxt_cur.st = aps_pkg::RX_DATA;
                        nxt_cur.cnt = baud_div_i - 20'h1;
                        nxt_cur.bitn = 3'h0;
                    end else begin
                        nxt_cur.st = aps_pkg::RX_IDLE;
                    end
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 20'h1;
                end
            end
            aps_pkg::RX_DATA: begin
                if (cur_ff.cnt == 20'h0) begin
                    nxt_cur.shreg = {cur_ff.rx_s2, cur_ff.shreg[7:1]};
                    nxt_cur.cnt = baud_div_i - 20'h1;
                    if (cur_ff.bitn == aps_pkg::DATA_BITS_LAST) begin
                        nxt_cur.st = aps_pkg::RX_STOP;
                    end else begin
                        nxt_cur.bitn = cur_ff.bitn + 3'h1;
                    end
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 20'h1;
                end
            end
            aps_pkg::RX_STOP: begin
                if (cur_ff.cnt == 20'h0) begin
                    // a low stop bit is a framing error: byte dropped
                    if (cur_ff.rx_s2) begin
                        nxt_cur.data = cur_ff.shreg;
                        nxt_cur.vld = 1'b1;
                    end
                    nxt_cur.st = aps_pkg::RX_IDLE;
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 20'h1;
                end
            end
            default: begin
                nxt_cur.st = aps_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cur_ff <= RX_RST;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign byte_o = cur_ff.data;
    assign byte_vld_o = cur_ff.vld;
endmodule : aps_uart_rx

// [dv/aps_point_parser_monitor.sv]
module aps_point_parser_monitor #(
    parameter int unsigned IDLE_CYCLES = aps_pkg::IDLE_CYCLES  // quiet cycles that end a download
) (
    input wire logic mclk_i,            // clock
    input wire logic rst_b_i,           // reset
    input wire logic rxd_i,             // serial line
    input wire logic [19:0] baud_div_i, // cycles per bit
    input wire logic sample_tick_i,     // playback tick
    input wire logic [11:0] dac_o,      // sample
    input wire logic sync_o,            // marker
    input wire logic playing_o,         // playing
    input wire logic loading_o,         // loading
    input wire logic [15:0] wave_len_o  // length
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles since the line was last low
    logic [31:0] quiet_ff;
    logic [31:0] nxt_quiet;
    always_comb begin
        nxt_quiet = quiet_ff;
        if (!rst_b_i || !rxd_i) begin
            nxt_quiet = 32'h0;
        end else if (quiet_ff != 32'hffffffff) begin
            nxt_quiet = quiet_ff + 32'h1;
        end
    end
    always_ff @(posedge mclk_i) begin
        quiet_ff <= nxt_quiet;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    idle_out_zero_a: assert property (!playing_o && !$past(playing_o) |-> dac_o == 12'h0 && !sync_o)
        else $error("output not zero while stopped");
    hold_till_tick_a: assert property (playing_o && $past(playing_o) && !$past(sample_tick_i)
        |-> $stable(dac_o) && $stable(sync_o)) else $error("sample moved without tick");
    reset_clear_a: assert property ($rose(rst_b_i) |-> dac_o == 12'h0 && !playing_o && !loading_o
        && wave_len_o == 16'h0) else $error("outputs not cleared by reset");
    len_bound_a: assert property (wave_len_o <= 16'h8000) else $error("length above store size");
    len_at_end_a: assert property ($changed(wave_len_o) |-> $fell(loading_o))
        else $error("length changed outside download end");
    start_play_a: assert property ($rose(playing_o) |-> $fell(loading_o) && wave_len_o != 16'h0)
        else $error("playback start without download end");
    idle_time_a: assert property ($rose(playing_o) |-> quiet_ff >= IDLE_CYCLES
        && quiet_ff <= IDLE_CYCLES + 10 * baud_div_i + 8) else $error("idle time wrong");
    stop_by_load_a: assert property ($fell(playing_o) |-> loading_o)
        else $error("playback stopped without header");
endmodule : aps_point_parser_monitor

// [dv/aps_host_model.sv]
module aps_host_model (
    input wire logic mclk_i,            // system clock
    input wire logic [19:0] baud_div_i, // cycles per bit
    output logic rxd_o                  // serial line, idle high
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd_o = 1'b1;
    // start bit, eight data bits lsb first, stop bit, no parity
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        @(negedge mclk_i);
        for (int i = 0; i < 10; i++) begin
            rxd_o = frame[i];
            repeat (baud_div_i) @(negedge mclk_i);
        end
    endtask : send_byte
    // characters leave in string order, so hex digits go msn first
    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++) begin
            send_byte(s[i]);
        end
    endtask : send_str
endmodule : aps_host_model

// [dv/aps_point_parser_test.sv]
module aps_point_parser_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned IDLE = 2000;
    localparam logic [19:0] DIV = 20'h14;
    logic mclk_i;
    logic rst_b_i;
    logic rxd;
    logic tick;
    logic [11:0] dac;
    logic sync;
    logic playing;
    logic loading;
    logic [15:0] wlen;
    int err_total = 0;
    int n_compared = 0;
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    aps_host_model aps_host_model_inst (.mclk_i(mclk_i), .baud_div_i(DIV), .rxd_o(rxd));
    aps_point_parser #(.IDLE_CYCLES(IDLE)) aps_point_parser_inst (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .rxd_i(rxd), .baud_div_i(DIV), .sample_tick_i(tick),
        .dac_o(dac), .sync_o(sync), .playing_o(playing), .loading_o(loading), .wave_len_o(wlen));
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // wait for the download to end, then judge playback state and length
    task automatic wait_end(input logic exp_play, input logic [15:0] exp_len);
        int n;
        n = 0;
        while (loading !== 1'b0 && n < 4 * IDLE) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= 4 * IDLE) begin
            check(16'h1, 16'h0, "download never ended");
            tally_and_finish();
        end
        check({15'h0, playing}, {15'h0, exp_play}, "playing");
        check(wlen, exp_len, "length");
    endtask : wait_end
    // ticks n samples and compares against the points, wrapping at the end
    task automatic play(input logic [15:0] pts[$], input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk_i);
            tick = 1'b1;
            @(negedge mclk_i);
            tick = 1'b0;
            @(negedge mclk_i);
            check({4'h0, dac}, {4'h0, pts[i % pts.size()][15:4]}, "sample");
            check({15'h0, sync}, {15'h0, pts[i % pts.size()][3]}, "marker");
        end
    endtask : play
    task automatic test_hex;
        logic [15:0] pts[$] = '{16'h1234, 16'hfed8, 16'h0007, 16'h8000, 16'h7fff, 16'habcd, 16'h0008};
        aps_host_model_inst.send_str("WH1234,FeD8 7;8000\n7fFf:abcde,08");
        check({4'h0, dac}, 16'h0, "sample before play");
        wait_end(1'b1, 16'h7);
        play(pts, 9);
        $display("hex test done");
    endtask : test_hex
    task automatic test_bin;
        logic [7:0] bytes[$] = '{8'h20, 8'h0a, 8'h80, 8'h00, 8'h7f, 8'hf7, 8'h00, 8'h08, 8'h55};
        logic [15:0] pts[$] = '{16'h200a, 16'h8000, 16'h7ff7, 16'h0008};
        aps_host_model_inst.send_str("Wb");
        check({15'h0, playing}, 16'h0, "stopped by header");
        check({4'h0, dac}, 16'h0, "sample after stop");
        // first byte is a space and still counts as data
        foreach (bytes[i]) aps_host_model_inst.send_byte(bytes[i]);
        wait_end(1'b1, 16'h4);
        play(pts, 5);
        $display("binary test done");
    endtask : test_bin
    task automatic test_other;
        string letters = "FIx";
        for (int i = 0; i < 3; i++) begin
            aps_host_model_inst.send_byte(8'h57);
            aps_host_model_inst.send_byte(letters[i]);
            aps_host_model_inst.send_str("0.5,12,");
            wait_end(1'b0, 16'h0);
        end
        $display("other formats test done");
    endtask : test_other
    initial begin
        rst_b_i = 1'b0;
        tick = 1'b0;
        repeat (16) @(negedge mclk_i);
        rst_b_i = 1'b1;
        test_hex();
        test_bin();
        test_other();
        tally_and_finish();
    end
endmodule : aps_point_parser_test
bind aps_point_parser aps_point_parser_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) aps_point_parser_monitor_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .rxd_i(rxd_i), .baud_div_i(baud_div_i), .sample_tick_i(sample_tick_i),
    .dac_o(dac_o), .sync_o(sync_o), .playing_o(playing_o), .loading_o(loading_o), .wave_len_o(wave_len_o));
